// File: rtl/tmt_pkg.sv
// package for the timer-two control and mode block
// assumes a single 50 MHz clock; shared by every design file except tmt_sync_edge
package tmt_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] TMT_CTRL_ADDR = 8'hC8; // timer_two_control
  localparam logic [7:0] TMT_MODE_ADDR = 8'hC9; // timer_two_mode
  localparam logic [7:0] TMT_CNT_LO_ADDR = 8'hCC; // counter_low
  localparam logic [7:0] TMT_CNT_HI_ADDR = 8'hCD; // counter_high
  localparam logic [7:0] TMT_CAP_LO_ADDR = 8'hCA; // capture_reload_low
  localparam logic [7:0] TMT_CAP_HI_ADDR = 8'hCB; // capture_reload_high
  // control field positions
  localparam int TMT_B_OVF = 7;
  localparam int TMT_B_EXT = 6;
  localparam int TMT_B_RXS = 5;
  localparam int TMT_B_TXS = 4;
  localparam int TMT_B_EXEN = 3;
  localparam int TMT_B_RUN = 2;
  localparam int TMT_B_SRC = 1;
  localparam int TMT_B_CRS = 0;
  // mode field positions
  localparam int TMT_B_CKOE = 1;
  localparam int TMT_B_UDEN = 0;
  // reset values
  localparam logic [7:0] TMT_CTRL_RST = 8'h00;
  localparam logic [1:0] TMT_MODE_RST = 2'h0;
  localparam logic [15:0] TMT_CNT_RST = 16'h0000;
  localparam logic [15:0] TMT_TOP = 16'hFFFF;
  localparam logic [5:0] TMT_MODE_UNDEF = 6'h00; // reserved bits read
  // ==========================================================
  // timing
  localparam int TMT_CLKOUT_DIV = 2; // clock-out advance divider

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmt_bus_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] mode;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [7:0] rdata;
    logic phase;
  } tmt_state_t;
endpackage

// File: rtl/tmt_sync_edge.sv
// two-stage synchroniser with falling-edge detect
// assumes asynchronous pin input; one instance per pin
`timescale 1ns/1ps
module tmt_sync_edge (
  input wire logic mclk_i, // system clock
  input wire logic rst_i, // async reset, high
  input wire logic pin_i, // raw pin
  output logic level_o, // synchronised level
  output logic fall_o // one-cycle falling pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tmt_sync_t;
  tmt_sync_t st_reg, st_next;

  // ==========================================================
  // s1 is read only by s2 to keep metastability contained
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= 3'h7;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.s2;
  assign fall_o = st_reg.s3 & ~st_reg.s2;
endmodule

// File: rtl/tmt_divider.sv
// enable pulse divider for the clock-out advance rate
// assumes single clock domain
`timescale 1ns/1ps
module tmt_divider (
  input wire logic mclk_i, // system clock
  input wire logic rst_i, // async reset, high
  input wire logic run_i, // divider runs
  output logic tick_o // one-cycle enable
);
  import tmt_pkg::*;
  typedef struct packed {
    logic [3:0] cnt;
  } tmt_div_t;
  tmt_div_t st_reg, st_next;

  // ==========================================================
  // free count, held cleared while stopped so phase is repeatable
  always_comb begin
    st_next = st_reg;
    if (!run_i) begin
      st_next.cnt = 4'h0;
    end else if (st_reg.cnt == 4'(TMT_CLKOUT_DIV - 1)) begin
      st_next.cnt = 4'h0;
    end else begin
      st_next.cnt = st_reg.cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= 4'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = run_i && (st_reg.cnt == 4'(TMT_CLKOUT_DIV - 1));
endmodule

// File: rtl/tmt_timer.sv
// timer-two control and mode block: 16-bit timer with capture/reload
// assumes pins are asynchronous; register port on the same clock
//
// Behaviour
// R1: overflow flag set unless baud clocking
// R2: event flag set on trigger capture/reload
// R3: event flag interrupts except up/down mode
// R4: bit5 selects receive baud clock
// R5: bit4 selects transmit baud clock
// R6: trigger enable gates pin, not baud
// R7: counts only while run bit set
// R8: source: peripheral clock or pin edges
// R9: software keeps source zero for clock-out
// R10: baud clocking forces reload on overflow
// R11: reload mode reloads on overflow, trigger
// R12: capture mode latches counter on trigger
// R13: mode bit1 makes pin clock output
// R14: mode bit0 enables up/down counting
// R15: control resets zero, bit writable
// R16: mode low bits reset zero
// R17: software never sets reserved mode bits
// R18: up count overflows FFFF, loads capture
// R19: down count underflows at capture, loads FFFF
// R20: up/down toggles event flag on wrap
// R21: clock-out half rate, reload, no interrupt
// R22: interrupt is OR of both flags
`timescale 1ns/1ps
module tmt_timer (
  input wire logic mclk_i, // 50 MHz clock
  input wire logic rst_i, // async reset, high
  input wire tmt_pkg::tmt_bus_t bus_i, // register port request
  output logic [7:0] rdata_o, // read data, cycle after read
  input wire logic count_pin_i, // count input pin
  input wire logic ext_trigger_pin_i, // trigger / direction pin
  output logic count_pin_o, // clock-out level
  output logic count_pin_oe_o, // clock-out drive enable
  output logic irq_o, // timer interrupt request
  output logic rx_baud_tick_o, // receive baud clock pulse
  output logic tx_baud_tick_o, // transmit baud clock pulse
  input wire logic timer1_ovf_i // timer 1 overflow pulse
);
  import tmt_pkg::*;

  tmt_state_t st_reg, st_next;
  logic cnt_fall, trg_lvl, trg_fall, half_tick;
  logic ovf_pulse, baud_mode, ckout_mode, updown;
  logic adv, wrap_up, wrap_dn, trig_act;
  logic reload_ovf;

  // ==========================================================
  // pin synchronisers and half-rate enable
  tmt_sync_edge u_cnt_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i(count_pin_i),
    .level_o(),
    .fall_o(cnt_fall)
  );

  tmt_sync_edge u_trg_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i(ext_trigger_pin_i),
    .level_o(trg_lvl),
    .fall_o(trg_fall)
  );

  tmt_divider u_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(st_reg.ctrl[TMT_B_RUN]),
    .tick_o(half_tick)
  );

  // ==========================================================
  // mode decode
  function automatic logic wr_hit(input tmt_bus_t b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  assign baud_mode = st_reg.ctrl[TMT_B_RXS] | st_reg.ctrl[TMT_B_TXS];
  assign ckout_mode = st_reg.mode[TMT_B_CKOE]; // R13
  assign updown = st_reg.mode[TMT_B_UDEN] && !baud_mode; // R14
  // clock-out advances at half rate; otherwise source select decides
  always_comb begin
    if (!st_reg.ctrl[TMT_B_RUN]) begin
      adv = 1'b0; // R7
    end else if (ckout_mode) begin
      adv = half_tick; // R21
    end else if (st_reg.ctrl[TMT_B_SRC]) begin
      adv = cnt_fall; // R8
    end else begin
      adv = 1'b1; // R8
    end
  end
  // direction pin high counts up in up/down mode
  assign wrap_up = adv && (st_reg.cnt == TMT_TOP) && !(updown && !trg_lvl); // R18
  assign wrap_dn = adv && updown && !trg_lvl && (st_reg.cnt == st_reg.cap); // R19
  assign ovf_pulse = wrap_up | wrap_dn;
  // trigger is ignored while the timer clocks the serial port
  assign trig_act = trg_fall && st_reg.ctrl[TMT_B_EXEN] && !baud_mode && !updown; // R6
  // capture mode alone lets the counter roll to zero; every other mode
  // reloads, so a capture timer keeps its full span between trigger edges
  assign reload_ovf = baud_mode || !st_reg.ctrl[TMT_B_CRS] || updown
    || ckout_mode; // R10 R11

  // ==========================================================
  // next-state: counter, flags, registers, read data
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    // counting
    if (wrap_up && reload_ovf) begin
      st_next.cnt = st_reg.cap; // R10 R11 R18 R21
    end else if (wrap_up) begin
      st_next.cnt = TMT_CNT_RST; // R10
    end else if (wrap_dn) begin
      st_next.cnt = TMT_TOP; // R19
    end else if (adv) begin
      if (updown && !trg_lvl) begin
        st_next.cnt = st_reg.cnt - 16'h0001;
      end else begin
        st_next.cnt = st_reg.cnt + 16'h0001;
      end
    end
    // trigger edge: capture or reload
    if (trig_act) begin
      if (st_reg.ctrl[TMT_B_CRS]) begin
        st_next.cap = st_reg.cnt; // R12
      end else begin
        st_next.cnt = st_reg.cap; // R11
      end
    end
    // software writes; hardware sets below win over clears
    if (wr_hit(bus_i, TMT_CTRL_ADDR)) begin
      st_next.ctrl = bus_i.wdata; // R15
    end
    if (wr_hit(bus_i, TMT_MODE_ADDR)) begin
      st_next.mode = bus_i.wdata[1:0]; // R16 R17
    end
    if (wr_hit(bus_i, TMT_CNT_LO_ADDR)) begin
      st_next.cnt[7:0] = bus_i.wdata;
    end
    if (wr_hit(bus_i, TMT_CNT_HI_ADDR)) begin
      st_next.cnt[15:8] = bus_i.wdata;
    end
    if (wr_hit(bus_i, TMT_CAP_LO_ADDR)) begin
      st_next.cap[7:0] = bus_i.wdata;
    end
    if (wr_hit(bus_i, TMT_CAP_HI_ADDR)) begin
      st_next.cap[15:8] = bus_i.wdata;
    end
    // flags: hardware clears only by the up/down event toggle; set beats a same-cycle write
    if (ovf_pulse && !baud_mode) begin
      st_next.ctrl[TMT_B_OVF] = 1'b1; // R1
    end
    if (updown && ovf_pulse) begin
      st_next.ctrl[TMT_B_EXT] = ~st_reg.ctrl[TMT_B_EXT]; // R20
    end else if (trig_act) begin
      st_next.ctrl[TMT_B_EXT] = 1'b1; // R2
    end
    // read mux
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        TMT_CTRL_ADDR: st_next.rdata = st_reg.ctrl;
        TMT_MODE_ADDR: st_next.rdata = {TMT_MODE_UNDEF, st_reg.mode};
        TMT_CNT_LO_ADDR: st_next.rdata = st_reg.cnt[7:0];
        TMT_CNT_HI_ADDR: st_next.rdata = st_reg.cnt[15:8];
        TMT_CAP_LO_ADDR: st_next.rdata = st_reg.cap[7:0];
        TMT_CAP_HI_ADDR: st_next.rdata = st_reg.cap[15:8];
        default: st_next.rdata = 8'h00;
      endcase
    end
    // clock-out toggles on each upward wrap for 50% duty
    if (ckout_mode && wrap_up) begin
      st_next.phase = ~st_reg.phase; // R21
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg.ctrl <= TMT_CTRL_RST;
      st_reg.mode <= TMT_MODE_RST;
      st_reg.cnt <= TMT_CNT_RST;
      st_reg.cap <= TMT_CNT_RST;
      st_reg.rdata <= 8'h00;
      st_reg.phase <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign rdata_o = st_reg.rdata;
  assign count_pin_o = st_reg.phase;
  assign count_pin_oe_o = ckout_mode; // R13
  // clock-out alone raises nothing, flag is still software-visible
  assign irq_o = (st_reg.ctrl[TMT_B_OVF] && !ckout_mode)
    || (st_reg.ctrl[TMT_B_EXT] && !st_reg.mode[TMT_B_UDEN]); // R3 R22
  assign rx_baud_tick_o = st_reg.ctrl[TMT_B_RXS] ? wrap_up : timer1_ovf_i; // R4
  assign tx_baud_tick_o = st_reg.ctrl[TMT_B_TXS] ? wrap_up : timer1_ovf_i; // R5

  // ==========================================================
  // checks
  a_ovf_flag_set: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
    (ovf_pulse && !baud_mode) |=> st_reg.ctrl[TMT_B_OVF])
    else $error("overflow flag not set");
  a_ovf_no_baud: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
    (!st_reg.ctrl[TMT_B_OVF] && baud_mode && !bus_i.wr) |=> !st_reg.ctrl[TMT_B_OVF])
    else $error("overflow flag set in baud mode");
  a_ext_flag_set: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
    trig_act |=> st_reg.ctrl[TMT_B_EXT])
    else $error("event flag not set");
  a_ext_no_irq: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
    (st_reg.mode[TMT_B_UDEN] && !st_reg.ctrl[TMT_B_OVF]) |-> !irq_o)
    else $error("irq in up/down mode");
  a_rx_select: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
    (!st_reg.ctrl[TMT_B_RXS]) |-> (rx_baud_tick_o == timer1_ovf_i))
    else $error("receive clock source wrong");
  a_run_stop: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
    (!st_reg.ctrl[TMT_B_RUN] && !trig_act && !bus_i.wr) |=> $stable(st_reg.cnt))
    else $error("counter moved while stopped");
  a_cap_latch: assert property (@(posedge mclk_i) disable iff (rst_i) // R12
    (trig_act && st_reg.ctrl[TMT_B_CRS] && !bus_i.wr) |=> st_reg.cap == $past(st_reg.cnt))
    else $error("capture missed");
  a_up_reload: assert property (@(posedge mclk_i) disable iff (rst_i) // R18
    (wrap_up && reload_ovf && !trig_act && !bus_i.wr) |=> st_reg.cnt == $past(st_reg.cap))
    else $error("reload on overflow missed");
  a_down_load: assert property (@(posedge mclk_i) disable iff (rst_i) // R19
    (wrap_dn && !bus_i.wr) |=> st_reg.cnt == TMT_TOP)
    else $error("underflow load missed");

  // timer 1 overflow passes straight through when not selected
  a_tx_select: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
    (!st_reg.ctrl[TMT_B_TXS]) |-> (tx_baud_tick_o == timer1_ovf_i))
    else $error("transmit clock source wrong");

  // own overflow must reach the receive clock when selected
  a_rx_own: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
    (st_reg.ctrl[TMT_B_RXS] && st_reg.ctrl[TMT_B_RUN] && !st_reg.ctrl[TMT_B_SRC]
      && !ckout_mode && (st_reg.cnt == TMT_TOP)) |-> rx_baud_tick_o)
    else $error("own overflow missing on receive clock");

  // baud clocking reloads whatever the capture bit says
  a_baud_reload: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
    (baud_mode && wrap_up && !bus_i.wr) |=> st_reg.cnt == $past(st_reg.cap))
    else $error("baud overflow did not reload");

  // capture mode keeps the capture pair and rolls the counter over
  a_cap_roll: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
    (wrap_up && !reload_ovf && !trig_act && !bus_i.wr) |=> st_reg.cnt == TMT_CNT_RST)
    else $error("capture mode overflow did not roll over");

  // up/down wraps flip the event flag as a seventeenth count bit
  a_ext_toggle: assert property (@(posedge mclk_i) disable iff (rst_i) // R20
    (updown && ovf_pulse && !bus_i.wr) |=> st_reg.ctrl[TMT_B_EXT] != $past(st_reg.ctrl[TMT_B_EXT]))
    else $error("event flag did not toggle");

  // clock-out overflows stay silent on the interrupt line
  a_ckout_quiet: assert property (@(posedge mclk_i) disable iff (rst_i) // R21
    (ckout_mode && !st_reg.ctrl[TMT_B_EXT]) |-> !irq_o)
    else $error("irq in clock-out mode");

  // clock-out advances never fall on two adjacent cycles
  a_half_rate: assert property (@(posedge mclk_i) disable iff (rst_i) // R21
    (ckout_mode && adv) |=> !(ckout_mode && adv))
    else $error("clock-out advanced at full rate");

  // pin drive follows the mode write one cycle later
  a_oe_mode: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
    wr_hit(bus_i, TMT_MODE_ADDR) |=> count_pin_oe_o == $past(bus_i.wdata[TMT_B_CKOE]))
    else $error("clock-out enable wrong");

  // up/down enable is taken from the written value
  a_updown_write: assert property (@(posedge mclk_i) disable iff (rst_i) // R14
    wr_hit(bus_i, TMT_MODE_ADDR) |=> st_reg.mode[TMT_B_UDEN] == $past(bus_i.wdata[TMT_B_UDEN]))
    else $error("up/down enable wrong");

  // a plain control write lands whole when no hardware set competes
  a_ctrl_write: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
    (wr_hit(bus_i, TMT_CTRL_ADDR) && !ovf_pulse && !trig_act) |=> st_reg.ctrl == $past(bus_i.wdata))
    else $error("control write lost");

  // a masked trigger edge touches neither capture pair nor event flag
  a_trig_masked: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
    (trg_fall && !st_reg.ctrl[TMT_B_EXEN] && !updown && !bus_i.wr)
      |=> ($stable(st_reg.cap) && !$rose(st_reg.ctrl[TMT_B_EXT])))
    else $error("masked trigger acted");

  // reload mode copies the capture pair in on a trigger edge
  a_trig_reload: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
    (trig_act && !st_reg.ctrl[TMT_B_CRS] && !bus_i.wr) |=> st_reg.cnt == $past(st_reg.cap))
    else $error("trigger reload missed");

  // pin source: no pin edge, no advance
  a_count_src: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
    (st_reg.ctrl[TMT_B_RUN] && st_reg.ctrl[TMT_B_SRC] && !ckout_mode && !cnt_fall
      && !trig_act && !bus_i.wr) |=> $stable(st_reg.cnt))
    else $error("counter moved without pin edge");

  // clock source: one step per cycle away from the wrap point
  a_timer_src: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
    (st_reg.ctrl[TMT_B_RUN] && !st_reg.ctrl[TMT_B_SRC] && !ckout_mode && !updown
      && !trig_act && !bus_i.wr && (st_reg.cnt != TMT_TOP))
      |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
    else $error("timer source step missed");
endmodule

// File: sim/tmt_timer_tb.sv
// self-checking bench for the timer-two control and mode block
// assumes tmt_pkg compiled first; drives the register port and pins directly
`timescale 1ns/1ps
module tmt_timer_tb;
  import tmt_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  tmt_bus_t bus_i = '0;
  logic count_pin_i = 1'b1;
  logic ext_trigger_pin_i = 1'b1;
  logic timer1_ovf_i = 1'b0;
  logic [7:0] rdata_o;
  logic count_pin_o, count_pin_oe_o, irq_o, rx_baud_tick_o, tx_baud_tick_o;
  int miscompares = 0;
  int samples_checked = 0;
  int rx_n, tx_n, t1_n, tog_n;
  logic [31:0] seed = 32'd95541;
  logic [7:0] rv, ra;
  logic pin_prev = 1'b0;

  tmt_timer i_tmt_timer (.mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .count_pin_i(count_pin_i), .ext_trigger_pin_i(ext_trigger_pin_i),
    .count_pin_o(count_pin_o), .count_pin_oe_o(count_pin_oe_o), .irq_o(irq_o),
    .rx_baud_tick_o(rx_baud_tick_o), .tx_baud_tick_o(tx_baud_tick_o),
    .timer1_ovf_i(timer1_ovf_i));

  // ==========================================================
  // clock and pulse counters
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    rx_n += int'(rx_baud_tick_o);
    tx_n += int'(tx_baud_tick_o);
    t1_n += int'(timer1_ovf_i);
    tog_n += int'(count_pin_o !== pin_prev);
    pin_prev = count_pin_o;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus_i.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_i.rd <= 1'b0;
    #1;
    chk({8'h00, exp}, {8'h00, rdata_o});
  endtask
  task automatic ld(input logic [15:0] cap, input logic [15:0] cnt);
    wr(TMT_CAP_LO_ADDR, cap[7:0]);
    wr(TMT_CAP_HI_ADDR, cap[15:8]);
    wr(TMT_CNT_LO_ADDR, cnt[7:0]);
    wr(TMT_CNT_HI_ADDR, cnt[15:8]);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // watchdog: whole sequence needs well under 5000 cycles
  initial begin
    #(20 * 20000);
    miscompares++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    cyc(6);
    rst_i <= 1'b0;
    rd_chk(TMT_CTRL_ADDR, 8'h00);
    rd_chk(TMT_MODE_ADDR, 8'h00);
    rd_chk(8'hC0, 8'h00);
    // random readback, reserved mode bits kept clear
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      rv = seed[7:0];
      ra = TMT_CAP_LO_ADDR + 8'(i % 4);
      wr(ra, rv);
      rd_chk(ra, rv);
    end
    wr(TMT_CTRL_ADDR, {2'b00, seed[13:12], 1'b0, 1'b0, seed[9:8]});
    rd_chk(TMT_CTRL_ADDR, {2'b00, seed[13:12], 1'b0, 1'b0, seed[9:8]});
    wr(TMT_MODE_ADDR, {6'h00, seed[17:16]});
    rd_chk(TMT_MODE_ADDR, {6'h00, seed[17:16]});
    wr(TMT_MODE_ADDR, 8'h00);
    // overflow, reload, stop
    ld(16'h1234, 16'hFFFA);
    wr(TMT_CTRL_ADDR, 8'h04);
    cyc(20);
    rd_chk(TMT_CTRL_ADDR, 8'h84);
    rd_chk(TMT_CNT_HI_ADDR, 8'h12);
    chk(16'h1, {15'h0, irq_o});
    wr(TMT_CTRL_ADDR, 8'h00);
    cyc(2);
    chk(16'h0, {15'h0, irq_o});
    wr(TMT_CNT_LO_ADDR, 8'h77);
    cyc(5);
    rd_chk(TMT_CNT_LO_ADDR, 8'h77);
    // capture mode: overflow sets the flag and rolls to zero
    ld(16'h1234, 16'hFFFC);
    wr(TMT_CTRL_ADDR, 8'h05);
    cyc(10);
    rd_chk(TMT_CNT_HI_ADDR, 8'h00);
    rd_chk(TMT_CTRL_ADDR, 8'h85);
    wr(TMT_CTRL_ADDR, 8'h00);
    // baud selects: timer 1 path, then own overflow with capture bit ignored
    ld(16'hFFF0, 16'hFFF0);
    for (int m = 0; m < 2; m++) begin
      // stop first so no overflow set lands on the mode write
      wr(TMT_CTRL_ADDR, 8'h00);
      wr(TMT_CTRL_ADDR, m ? 8'h35 : 8'h04);
      cyc(3);
      rx_n = 0;
      tx_n = 0;
      t1_n = 0;
      repeat (100) begin
        seed = lfsr_next(seed);
        @(posedge mclk_i);
        timer1_ovf_i <= seed[0];
      end
      @(posedge mclk_i);
      timer1_ovf_i <= 1'b0;
      cyc(4);
      if (m == 0) begin
        chk(16'(t1_n), 16'(rx_n));
        chk(16'(t1_n), 16'(tx_n));
        rd_chk(TMT_CTRL_ADDR, 8'h84);
      end else begin
        chk(16'(rx_n), 16'(tx_n));
        chk(16'h1, 16'(rx_n >= 5));
        rd_chk(TMT_CTRL_ADDR, 8'h35);
      end
    end
    // trigger: ignored, capture, reload
    wr(TMT_CTRL_ADDR, 8'h00);
    ld(16'h0000, 16'h5500);
    for (int k = 0; k < 3; k++) begin
      wr(TMT_CTRL_ADDR, k == 0 ? 8'h05 : (k == 1 ? 8'h0D : 8'h0C));
      @(posedge mclk_i);
      ext_trigger_pin_i <= 1'b0;
      cyc(8);
      ext_trigger_pin_i <= 1'b1;
      cyc(4);
      if (k == 0) rd_chk(TMT_CTRL_ADDR, 8'h05);
      if (k == 0) rd_chk(TMT_CAP_HI_ADDR, 8'h00);
      if (k == 1) rd_chk(TMT_CTRL_ADDR, 8'h4D);
      if (k == 1) rd_chk(TMT_CAP_HI_ADDR, 8'h77);
      if (k == 1) chk(16'h1, {15'h0, irq_o});
      if (k == 2) rd_chk(TMT_CNT_HI_ADDR, 8'h55);
      wr(TMT_CTRL_ADDR, 8'h00);
      ld(16'h5500, 16'h7700);
    end
    // up/down, trigger pin low counts down to capture
    wr(TMT_MODE_ADDR, 8'h01);
    ext_trigger_pin_i <= 1'b0;
    ld(16'h1000, 16'h1008);
    wr(TMT_CTRL_ADDR, 8'h04);
    cyc(20);
    rd_chk(TMT_CNT_HI_ADDR, 8'hFF);
    rd_chk(TMT_CTRL_ADDR, 8'hC4);
    wr(TMT_CTRL_ADDR, 8'h40);
    cyc(2);
    chk(16'h0, {15'h0, irq_o});
    // up/down, pin high counts up and reloads from capture
    ext_trigger_pin_i <= 1'b1;
    ld(16'h2300, 16'hFFF8);
    wr(TMT_CTRL_ADDR, 8'h04);
    cyc(20);
    rd_chk(TMT_CNT_HI_ADDR, 8'h23);
    rd_chk(TMT_CTRL_ADDR, 8'hC4);
    wr(TMT_CTRL_ADDR, 8'h00);
    wr(TMT_MODE_ADDR, 8'h00);
    // pin as count source, five falling edges
    ld(16'h0000, 16'h0000);
    wr(TMT_CTRL_ADDR, 8'h06);
    repeat (5) begin
      @(posedge mclk_i);
      count_pin_i <= 1'b0;
      cyc(5);
      count_pin_i <= 1'b1;
      cyc(5);
    end
    rd_chk(TMT_CNT_LO_ADDR, 8'h05);
    // clock-out: half rate, reload, no interrupt
    wr(TMT_CTRL_ADDR, 8'h00);
    wr(TMT_MODE_ADDR, 8'h02);
    cyc(2);
    chk(16'h1, {15'h0, count_pin_oe_o});
    ld(16'hFFF8, 16'hFFF8);
    wr(TMT_CTRL_ADDR, 8'h04);
    cyc(2);
    tog_n = 0;
    cyc(160);
    chk(16'h1, 16'(tog_n >= 8 && tog_n <= 11));
    chk(16'h0, {15'h0, irq_o});
    wr(TMT_MODE_ADDR, 8'h00);
    cyc(2);
    chk(16'h0, {15'h0, count_pin_oe_o});
    stop_test();
  end
endmodule
